// ===== rtl/swd_top.sv
// Supervisor watchdog timing and status logic.
// Assumes strobe mid level, supply and monitor comparisons arrive decoded.
`timescale 1ns/100ps
module swd_top
   import swd_pkg::*;
#(
   parameter int unsigned DIV       = INT_DIV,
   parameter int unsigned WD_SLOW   = WD_SLOW_TICKS,
   parameter int unsigned WD_FAST   = WD_FAST_TICKS,
   parameter int unsigned RST_TIME  = RST_TICKS
) (
   input  wire logic CLK,
   input  wire logic RSTN,
   input  wire logic WATCHDOG_STROBE_IN,
   input  wire logic WATCHDOG_STROBE_MID,
   input  wire logic TIMEBASE_SELECT,
   input  wire logic TIMEBASE_IN,
   input  wire logic SUPPLY_LOW_IN,
   input  wire logic BACKUP_SELECT_IN,
   input  wire logic MONITOR_LOW_IN,
   output logic      WATCHDOG_FAULT_OUT,
   output logic      WATCHDOG_RESET_OUT,
   output logic      SUPPLY_LOW_N_OUT,
   output logic      BACKUP_ACTIVE_OUT,
   output logic      MONITOR_FAIL_OUT
);
   localparam int SYNC_W = 7;

   logic [SYNC_W-1:0] pins_s;
   logic              stb_s;
   logic              stb_mid_s;
   logic              tb_sel_s;
   logic              tb_in_s;
   swd_supply_s       sup_s;
   swd_strobe_e       stb_lvl;

   // Pin synchronisers
   swd_sync #(
      .W    (SYNC_W)
   ) u_sync (
      .clk  (CLK),
      .rst_n(RSTN),
      .din  ({WATCHDOG_STROBE_IN, WATCHDOG_STROBE_MID, TIMEBASE_SELECT,
              TIMEBASE_IN, SUPPLY_LOW_IN, BACKUP_SELECT_IN,
              MONITOR_LOW_IN}),
      .dout (pins_s)
   );

   // Unpack synchronised pins
   assign stb_s     = pins_s[6];
   assign stb_mid_s = pins_s[5];
   assign tb_sel_s  = pins_s[4];
   assign tb_in_s   = pins_s[3];
   assign sup_s     = swd_supply_s'(pins_s[2:0]);

   // Three-level decode of the strobe
   always_comb begin
      if (stb_mid_s) begin
         stb_lvl = SWD_STB_MID;
      end else if (stb_s) begin
         stb_lvl = SWD_STB_HIGH;
      end else begin
         stb_lvl = SWD_STB_LOW;
      end
   end

   // Edge detect and time-base tick state
   logic              stb_prev_q, stb_prev_d;
   logic              tb_prev_q, tb_prev_d;
   logic [CNT_W-1:0]  div_q, div_d;
   logic              tick;
   logic              activity;

   always_comb begin
      stb_prev_d = stb_s;
      tb_prev_d  = tb_in_s;
      div_d      = div_q;
      tick       = 1'b0;
      if (!tb_sel_s) begin
         // External source: each rising edge is one tick
         div_d = '0;
         tick  = tb_in_s & ~tb_prev_q;
      end else if (div_q == CNT_W'(DIV - 1)) begin
         div_d = '0;
         tick  = 1'b1;
      end else begin
         div_d = div_q + CNT_W'(1);
      end
   end

   // Any change outside mid level, even one sampled pulse edge, counts as activity
   assign activity = (stb_s != stb_prev_q) &&
                     (stb_lvl != SWD_STB_MID);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         stb_prev_q <= 1'b0;
         tb_prev_q  <= 1'b0;
         div_q      <= '0;
      end else begin
         stb_prev_q <= stb_prev_d;
         tb_prev_q  <= tb_prev_d;
         div_q      <= div_d;
      end
   end

   // Watchdog period picked from source and level
   logic [CNT_W-1:0] wd_limit;

   always_comb begin
      if (tb_sel_s && !tb_in_s) begin
         wd_limit = CNT_W'(WD_FAST);
      end else begin
         wd_limit = CNT_W'(WD_SLOW);
      end
   end

   // Watchdog state machine
   swd_state_e       state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             fault_q, fault_d;
   logic             rst_q, rst_d;
   logic             wd_off;

   assign wd_off = sup_s.supply_low | sup_s.backup_sel |
                   (stb_lvl == SWD_STB_MID);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      fault_d = fault_q;
      rst_d   = 1'b0;
      if (wd_off) begin
         state_d = SWD_IDLE;
         cnt_d   = '0;
         fault_d = 1'b1;
      end else begin
         unique case (state_q)
            SWD_IDLE: begin
               state_d = SWD_WATCH;
               cnt_d   = '0;
               fault_d = 1'b1;
            end
            SWD_WATCH: begin
               if (activity) begin
                  cnt_d   = '0;
                  fault_d = 1'b1;
               end else if (tick) begin
                  if (cnt_q >= wd_limit - CNT_W'(1)) begin
                     state_d = SWD_RESET;
                     cnt_d   = '0;
                     fault_d = 1'b0;
                     rst_d   = 1'b1;
                  end else begin
                     cnt_d = cnt_q + CNT_W'(1);
                  end
               end
            end
            SWD_RESET: begin
               rst_d = 1'b1;
               if (activity) begin
                  fault_d = 1'b1;
               end
               if (tick) begin
                  if (cnt_q >= CNT_W'(RST_TIME) - CNT_W'(1)) begin
                     state_d = SWD_HOLD;
                     cnt_d   = '0;
                     rst_d   = 1'b0;
                  end else begin
                     cnt_d = cnt_q + CNT_W'(1);
                  end
               end
            end
            SWD_HOLD: begin
               // Fresh watchdog period after the pulse
               state_d = SWD_WATCH;
               cnt_d   = '0;
               if (activity) begin
                  fault_d = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= SWD_IDLE;
         cnt_q   <= '0;
         fault_q <= 1'b1;
         rst_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         fault_q <= fault_d;
         rst_q   <= rst_d;
      end
   end

   // Status outputs registered from synchronised indications
   logic sup_n_q, sup_n_d;
   logic bak_q, bak_d;
   logic mon_q, mon_d;

   always_comb begin
      sup_n_d = ~sup_s.supply_low;
      bak_d   = sup_s.backup_sel;
      mon_d   = ~sup_s.monitor_low;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sup_n_q <= 1'b0;
         bak_q   <= 1'b0;
         mon_q   <= 1'b1;
      end else begin
         sup_n_q <= sup_n_d;
         bak_q   <= bak_d;
         mon_q   <= mon_d;
      end
   end

   assign WATCHDOG_FAULT_OUT = fault_q;
   assign WATCHDOG_RESET_OUT = rst_q;
   assign SUPPLY_LOW_N_OUT   = sup_n_q;
   assign BACKUP_ACTIVE_OUT  = bak_q;
   assign MONITOR_FAIL_OUT   = mon_q;
endmodule : swd_top

// ===== rtl/swd_pkg.sv
// Package for the supervisor watchdog timing block.
// Assumes a 40 MHz system clock; analog levels arrive already decoded.
package swd_pkg;

   // System clock rate
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned CLK_PERIOD_NS = 25;

   // Internal oscillator rate and derived divider
   localparam int unsigned INT_OSC_HZ    = 10_000;
   localparam int unsigned INT_DIV       = CLK_HZ / INT_OSC_HZ;

   // Timeouts as printed, in milliseconds
   localparam int unsigned WD_SLOW_MS    = 1600;
   localparam int unsigned WD_FAST_MS    = 100;
   localparam int unsigned RST_MS        = 200;

   // Timeouts as fixed tick counts of the selected time base
   localparam int unsigned WD_SLOW_TICKS = WD_SLOW_MS * INT_OSC_HZ / 1000;
   localparam int unsigned WD_FAST_TICKS = WD_FAST_MS * INT_OSC_HZ / 1000;
   localparam int unsigned RST_TICKS     = RST_MS * INT_OSC_HZ / 1000;

   // Minimum strobe pulse width; unused, any sampled strobe change outside mid level counts as activity
   localparam int unsigned MIN_PULSE_NS  = 100;
   localparam int unsigned MIN_PULSE_CYC =
      (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int unsigned CNT_W         = 16;

   // Three-level strobe decode
   typedef enum logic [1:0] {
      SWD_STB_LOW  = 2'h0,
      SWD_STB_HIGH = 2'h1,
      SWD_STB_MID  = 2'h3
   } swd_strobe_e;

   // Supply monitor indications, already decided by comparators
   typedef struct packed {
      logic supply_low;
      logic backup_sel;
      logic monitor_low;
   } swd_supply_s;

   // Watchdog states, Gray from IDLE through HOLD; HOLD back to WATCH flips both bits
   typedef enum logic [1:0] {
      SWD_IDLE  = 2'b00,
      SWD_WATCH = 2'b01,
      SWD_RESET = 2'b11,
      SWD_HOLD  = 2'b10
   } swd_state_e;

endpackage : swd_pkg

// ===== rtl/swd_sync.sv
// Two flip-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to CLK.
`timescale 1ns/100ps
module swd_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Per-bit two-stage chain
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q[i] <= 1'b0;
            sync_q[i] <= 1'b0;
         end else begin
            meta_q[i] <= din[i];
            sync_q[i] <= meta_q[i];
         end
      end
   end

   assign dout = sync_q;
endmodule : swd_sync

// ===== dv/swd_top_assertions.sv
// Checker of watchdog timing and status outputs.
// Assumes it is bound to the top block with short tick counts.
`timescale 1ns/100ps
module swd_chk #(
   parameter int unsigned DIV      = 4,
   parameter int unsigned RST_TIME = 2
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic WATCHDOG_STROBE_IN,
   input wire logic WATCHDOG_STROBE_MID,
   input wire logic TIMEBASE_SELECT,
   input wire logic SUPPLY_LOW_IN,
   input wire logic BACKUP_SELECT_IN,
   input wire logic MONITOR_LOW_IN,
   input wire logic WATCHDOG_FAULT_OUT,
   input wire logic WATCHDOG_RESET_OUT,
   input wire logic SUPPLY_LOW_N_OUT,
   input wire logic BACKUP_ACTIVE_OUT,
   input wire logic MONITOR_FAIL_OUT
);
   // Short aliases and the disable condition
   wire         mid = WATCHDOG_STROBE_MID;
   wire         off = mid | SUPPLY_LOW_IN | BACKUP_SELECT_IN;
   wire         flt = WATCHDOG_FAULT_OUT;
   wire         wr  = WATCHDOG_RESET_OUT;
   int unsigned n_q;
   int unsigned n_d;
   // Cycles the reset pulse has stood
   always_comb n_d = wr ? n_q + 1 : 0;
   always_ff @(posedge CLK or negedge RSTN)
      if (!RSTN) n_q <= 0;
      else n_q <= n_d;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence s_kick;
      $changed(WATCHDOG_STROBE_IN) && !off;
   endsequence
   sequence s_trip;
      $fell(flt);
   endsequence
   a_status_supply: assert property (
      $past(RSTN, 3) |-> SUPPLY_LOW_N_OUT == !$past(SUPPLY_LOW_IN, 3))
      else $error("supply low status lags");
   a_status_backup: assert property (
      $past(RSTN, 3) |-> BACKUP_ACTIVE_OUT == $past(BACKUP_SELECT_IN, 3))
      else $error("backup status lags");
   a_status_monitor: assert property (
      $past(RSTN, 3) |-> MONITOR_FAIL_OUT == !$past(MONITOR_LOW_IN, 3))
      else $error("monitor status lags");
   a_trip_together: assert property (s_trip |-> $rose(wr))
      else $error("fault fell without reset");
   a_retrip_low: assert property ($rose(wr) |-> !flt)
      else $error("reset rose with fault high");
   a_reset_width: assert property (
      $fell(wr) && TIMEBASE_SELECT |-> n_q == RST_TIME * DIV)
      else $error("reset pulse width");
   a_kick_clears: assert property (s_kick |-> ##[1:4] flt)
      else $error("strobe change left fault low");
   a_idle_fault: assert property (off [*4] |=> flt)
      else $error("disabled watchdog shows fault");
   a_mid_off: assert property (mid [*4] |=> flt && !wr)
      else $error("mid level strobe still active");
endmodule : swd_chk
bind swd_top swd_chk #(.DIV(DIV), .RST_TIME(RST_TIME)) i_chk (
   .CLK, .RSTN, .WATCHDOG_STROBE_IN, .WATCHDOG_STROBE_MID,
   .TIMEBASE_SELECT, .SUPPLY_LOW_IN, .BACKUP_SELECT_IN, .MONITOR_LOW_IN,
   .WATCHDOG_FAULT_OUT, .WATCHDOG_RESET_OUT, .SUPPLY_LOW_N_OUT,
   .BACKUP_ACTIVE_OUT, .MONITOR_FAIL_OUT);

// ===== dv/swd_host.sv
// Host model that toggles the watchdog strobe.
// Assumes the bench sets enable and gap at the falling edge.
`timescale 1ns/100ps
module swd_host (
   input  wire logic        clk,
   input  wire logic        en,
   input  wire logic [15:0] gap,
   output logic             strobe
);
   logic [15:0] cnt_q = 16'h0;
   initial strobe = 1'b0;
   // Toggle once per gap cycles, on the rising edge so enable is settled
   always @(posedge clk) begin
      if (!en) cnt_q <= 16'h0;
      else if (cnt_q + 16'h1 >= gap) begin
         cnt_q  <= 16'h0;
         strobe <= ~strobe;
      end else cnt_q <= cnt_q + 16'h1;
   end
endmodule : swd_host

// ===== dv/tb.sv
// Self-checking bench for the watchdog timing block.
// Assumes the host model drives the strobe; counts are shortened.
`timescale 1ns/100ps
module tb;
   import swd_pkg::*;
   localparam int D = 4, W = 16, F = 4, R = 2;
   logic        clk = 1'b0, rstn = 1'b0, mid = 1'b0, sel = 1'b1;
   logic        lvl = 1'b1, ext = 1'b0, h_en = 1'b0;
   logic [15:0] gap = 16'h8;
   swd_supply_s sup = '0;
   wire         stb, fault, wrst, low_n, bat, mon_n;
   int          n_errors = 0, checks_done = 0, k = 0, n;
   // Clock and external time base of 10 cycles
   always #12.5 clk = ~clk;
   always @(negedge clk) begin
      k <= k + 1;
      if (k % 5 == 4) ext <= ~ext;
   end
   swd_top #(.DIV(D), .WD_SLOW(W), .WD_FAST(F), .RST_TIME(R)) i_dut (
      .CLK(clk), .RSTN(rstn), .WATCHDOG_STROBE_IN(stb),
      .WATCHDOG_STROBE_MID(mid), .TIMEBASE_SELECT(sel),
      .TIMEBASE_IN(sel ? lvl : ext), .SUPPLY_LOW_IN(sup.supply_low),
      .BACKUP_SELECT_IN(sup.backup_sel), .MONITOR_LOW_IN(sup.monitor_low),
      .WATCHDOG_FAULT_OUT(fault), .WATCHDOG_RESET_OUT(wrst),
      .SUPPLY_LOW_N_OUT(low_n), .BACKUP_ACTIVE_OUT(bat),
      .MONITOR_FAIL_OUT(mon_n));
   swd_host i_host (.clk(clk), .en(h_en), .gap(gap), .strobe(stb));
   // Verdict and end of run
   task automatic conclude;
      if (n_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   function automatic int span(input int t, input int d);
      return t * d;
   endfunction : span
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: output bit", $time);
      end
   endtask : chk_bit
   task automatic chk_rng(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("wrong value at %0t: span %0d", $time, got);
      end
   endtask : chk_rng
   // Count falling edges until the chosen output shows v
   task automatic wait_for(input bit rs, input logic v, output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
         if (c > 4000) begin
            n_errors++;
            conclude();
         end
      end while ((rs ? wrst : fault) !== v);
   endtask : wait_for
   // No reset and no fault for c cycles
   task automatic quiet(input int c);
      logic ok;
      ok = 1'b1;
      repeat (c) begin
         @(negedge clk);
         if (wrst !== 1'b0 || fault !== 1'b1) ok = 1'b0;
      end
      chk_bit(ok, 1'b1);
   endtask : quiet
   // Stale strobe: time two pulses, then clear the fault
   task automatic trip(input logic s, l, input int lo, hi, d);
      sel = s;
      lvl = l;
      sup = swd_supply_s'({2'b00, 1'($urandom)});
      gap = 16'(5 + $urandom % 36);
      h_en = 1'b1;
      repeat (40) @(negedge clk);
      h_en = 1'b0;
      wait_for(1'b1, 1'b0, n);
      wait_for(1'b1, 1'b1, n);
      wait_for(1'b1, 1'b0, n);
      chk_rng(n, span(R, d), span(R, d));
      wait_for(1'b1, 1'b1, n);
      chk_rng(n, span(lo, d), span(hi, d) + 1);
      chk_bit(fault, 1'b0);
      h_en = 1'b1;
      wait_for(1'b0, 1'b1, n);
      chk_rng(n, 1, int'(gap) + 4);
      wait_for(1'b1, 1'b0, n);
   endtask : trip
   initial begin
      void'($urandom(32'hBB53));
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      // Status outputs track random indications
      repeat (24) begin
         sup = swd_supply_s'(3'($urandom));
         repeat (4) @(negedge clk);
         chk_bit(low_n, ~sup.supply_low);
         chk_bit(bat, sup.backup_sel);
         chk_bit(mon_n, ~sup.monitor_low);
      end
      // Each time base and period choice
      trip(1'b1, 1'b1, W, W, D);
      trip(1'b1, 1'b0, F, F, D);
      trip(1'b0, 1'b1, W, W, 10);
      trip(1'b1, 1'b1, W, W, D);
      // Steady activity, mid level, low supply and backup stay quiet
      repeat (20) @(negedge clk);
      quiet(span(W + R, D) * 3);
      h_en = 1'b0;
      mid = 1'b1;
      quiet(span(W + R, D) * 2);
      sup.supply_low = 1'b1;
      mid = 1'b0;
      quiet(span(W + R, D) * 2);
      sup = swd_supply_s'(3'b010);
      quiet(span(W + R, D) * 2);
      conclude();
   end
endmodule : tb
